// ---- hdl/dqf_cmd_frame.v ----
// Command framing layer of a dual-quad serial flash, device side
//
// Overview of operation
// - Select low frames command; rising select ends it
// - Eight instruction bits, single lane, rising edges
// - Instruction picks address space, 24 or 32 bits
// - Address on rising edges, both edges in DDR
// - Mode bits enter or leave continuous read
// - Quad address repeated on both halves; bytes out
// - Instruction sets single-bit or quad transfer width
// - Lane 0 carries nibble LSB; groups MSB first
// - All fields shifted most significant bit first
// - Whole bytes, lowest address first, address increments
// - Write data on rising edges, both in DDR
// - First read data at fall ending latency
// - Later transfers each fall, or each DDR edge
// - Read data continues until select rises
// - Non-read commands end on eight-clock boundary
// - Array reads ignored during embedded operation
// - Only restricted commands accepted while busy
// - Status read reports completion and success
// - First address bit is bit 23 or 31
// - Output changes after fall, or every DDR edge
// - Select high: inputs ignored, outputs released
// - DDR instruction on rises; address from next rise
`timescale 1ns/100ps
`default_nettype none
`include "dqf_defs.vh"

module dqf_cmd_frame #(
    parameter [3:0] CONT_MODE_NIB = 4'hA
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Serial link pins
    input wire sck_in,
    input wire sel_n_in,
    input wire [7:0] lanes_in,
    output reg [7:0] lanes_out,
    output reg [7:0] lanes_oe_out,
    // Instruction and its decode, answered in the same cycle as the pulse
    output reg [7:0] inst_out,
    output reg inst_valid_out,
    input wire dec_addr_in,
    input wire dec_addr32_in,
    input wire dec_quad_in,
    input wire dec_ddr_in,
    input wire dec_mode_in,
    input wire [4:0] dec_dummy_in,
    input wire dec_read_in,
    input wire dec_write_in,
    input wire dec_array_in,
    input wire dec_busy_ok_in,
    // Embedded operation state
    input wire busy_in,
    // Address and mode
    output reg [31:0] addr_out,
    output reg addr_valid_out,
    output reg [7:0] mode_out,
    output reg cont_mode_out,
    // Write data, one byte per quad half
    output reg [15:0] wr_data_out,
    output reg wr_valid_out,
    // Read data, one byte per quad half, for the byte at addr_out
    input wire [15:0] rd_data_in,
    output reg rd_take_out,
    // Command end
    output reg cmd_exec_out,
    output reg cmd_reject_out
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function [5:0] beat_bits;
        input quad;
        begin
            beat_bits = quad ? 6'h04 : 6'h01;
        end
    endfunction

    // Shift one beat into a 32-bit MSB-first accumulator
    function [31:0] shift_beat;
        input [31:0] acc;
        input quad;
        input [3:0] nib;
        begin
            if (quad) begin
                shift_beat = {acc[27:0], nib};
            end else begin
                shift_beat = {acc[30:0], nib[0]};
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
    reg sel_s1_reg, sel_s2_reg, sel_s3_reg;
    reg [7:0] lanes_s1_reg, lanes_s2_reg;

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            sel_s1_reg <= 1'b1;
            sel_s2_reg <= 1'b1;
            sel_s3_reg <= 1'b1;
            lanes_s1_reg <= `DQF_RST_LANES;
            lanes_s2_reg <= `DQF_RST_LANES;
        end else begin
            sck_s1_reg <= sck_in;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            sel_s1_reg <= sel_n_in;
            sel_s2_reg <= sel_s1_reg;
            sel_s3_reg <= sel_s2_reg;
            lanes_s1_reg <= lanes_in;
            lanes_s2_reg <= lanes_s1_reg;
        end
    end

    wire sck_rise = sck_s2_reg & ~sck_s3_reg;
    wire sck_fall = ~sck_s2_reg & sck_s3_reg;
    wire sel_fall = ~sel_s2_reg & sel_s3_reg;
    wire sel_rise = sel_s2_reg & ~sel_s3_reg;
    wire selected = ~sel_s2_reg;

    // ----------------------------------------------------------------
    // Framing state
    // ----------------------------------------------------------------
    reg [2:0] state_reg;
    reg [5:0] bcnt_reg;
    reg [2:0] clk8_reg;
    reg [31:0] acc_reg;
    reg [15:0] wsh_reg;
    reg [15:0] osh_reg;
    reg [3:0] oleft_reg;
    reg [4:0] dcnt_reg;
    reg got_rise_reg;
    reg driving_reg;
    reg addr_reg, a32_reg, quad_reg, ddr_reg, mode_reg;
    reg rd_reg, wr_reg;
    reg [4:0] dummy_reg;

    // Capture edges: rises always, falls only in DDR after the first rise
    wire cap_ev = sck_rise | (ddr_reg & sck_fall & got_rise_reg);
    // Output edges: falls in SDR, every edge in DDR once data flows
    wire out_ev = sck_fall | (ddr_reg & sck_rise & driving_reg);
    wire [5:0] step = beat_bits(quad_reg);
    wire [5:0] alen = a32_reg ? `DQF_ADDR_BITS_4B : `DQF_ADDR_BITS_3B;
    wire [31:0] acc_in = shift_beat(acc_reg, quad_reg, lanes_s2_reg[3:0]);

    // Read byte source: reload from the memory side when a byte is used
    wire reload = (oleft_reg == 4'h0);
    wire [15:0] src = reload ? rd_data_in : osh_reg;
    // The fall ending the last latency cycle launches the first bits
    wire first_out = (state_reg == `DQF_ST_DUMMY) && sck_fall &&
        (dcnt_reg >= dummy_reg);

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= `DQF_ST_IDLE;
            bcnt_reg <= 6'h00;
            clk8_reg <= 3'h0;
            acc_reg <= `DQF_RST_ADDR;
            wsh_reg <= `DQF_RST_PAIR;
            osh_reg <= `DQF_RST_PAIR;
            oleft_reg <= 4'h0;
            dcnt_reg <= 5'h00;
            got_rise_reg <= 1'b0;
            driving_reg <= 1'b0;
            addr_reg <= 1'b0;
            a32_reg <= 1'b0;
            quad_reg <= 1'b0;
            ddr_reg <= 1'b0;
            mode_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            dummy_reg <= 5'h00;
            lanes_out <= `DQF_RST_LANES;
            lanes_oe_out <= `DQF_RST_LANES;
            inst_out <= `DQF_RST_BYTE;
            inst_valid_out <= 1'b0;
            addr_out <= `DQF_RST_ADDR;
            addr_valid_out <= 1'b0;
            mode_out <= `DQF_RST_BYTE;
            cont_mode_out <= 1'b0;
            wr_data_out <= `DQF_RST_PAIR;
            wr_valid_out <= 1'b0;
            rd_take_out <= 1'b0;
            cmd_exec_out <= 1'b0;
            cmd_reject_out <= 1'b0;
        end else begin
            inst_valid_out <= 1'b0;
            addr_valid_out <= 1'b0;
            wr_valid_out <= 1'b0;
            rd_take_out <= 1'b0;
            cmd_exec_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            if (selected && sck_rise) begin
                clk8_reg <= clk8_reg + 3'h1;
            end
            if (sel_rise) begin
                // Only commands that return no data are checked
                if (state_reg == `DQF_ST_HOLD ||
                        (state_reg == `DQF_ST_XFER && wr_reg)) begin
                    if (clk8_reg == `DQF_CLK_MOD8_ZERO) begin
                        cmd_exec_out <= 1'b1;
                    end else begin
                        cmd_reject_out <= 1'b1;
                    end
                end else if (state_reg == `DQF_ST_INST ||
                        (state_reg == `DQF_ST_ADDR && !rd_reg) ||
                        state_reg == `DQF_ST_DECODE) begin
                    cmd_reject_out <= 1'b1;
                end
                state_reg <= `DQF_ST_IDLE;
                driving_reg <= 1'b0;
                lanes_oe_out <= `DQF_RST_LANES;
            end else if (!selected) begin
                state_reg <= `DQF_ST_IDLE;
                lanes_oe_out <= `DQF_RST_LANES;
            end else if (sel_fall) begin
                bcnt_reg <= 6'h00;
                clk8_reg <= 3'h0;
                acc_reg <= `DQF_RST_ADDR;
                got_rise_reg <= 1'b0;
                driving_reg <= 1'b0;
                oleft_reg <= 4'h0;
                if (cont_mode_out) begin
                    // Implied instruction: go straight to the address
                    if (busy_in) begin
                        // Idle, not hold: a refused read pulses no outcome
                        state_reg <= `DQF_ST_IDLE;
                    end else begin
                        state_reg <= `DQF_ST_ADDR;
                    end
                end else begin
                    state_reg <= `DQF_ST_INST;
                end
            end else begin
                case (state_reg)
                    `DQF_ST_INST: begin
                        if (sck_rise) begin
                            // Lane 0 of the first half; the host mirrors it
                            acc_reg <= {acc_reg[30:0], lanes_s2_reg[0]};
                            bcnt_reg <= bcnt_reg + 6'h01;
                            if (bcnt_reg + 6'h01 == `DQF_INST_BITS) begin
                                inst_out <= {acc_reg[6:0], lanes_s2_reg[0]};
                                inst_valid_out <= 1'b1;
                                state_reg <= `DQF_ST_DECODE;
                            end
                        end
                    end
                    `DQF_ST_DECODE: begin
                        addr_reg <= dec_addr_in;
                        a32_reg <= dec_addr32_in;
                        quad_reg <= dec_quad_in;
                        ddr_reg <= dec_ddr_in;
                        mode_reg <= dec_mode_in;
                        dummy_reg <= dec_dummy_in;
                        rd_reg <= dec_read_in;
                        wr_reg <= dec_write_in;
                        bcnt_reg <= 6'h00;
                        acc_reg <= `DQF_RST_ADDR;
                        got_rise_reg <= 1'b0;
                        if (busy_in &&
                                (dec_array_in || !dec_busy_ok_in)) begin
                            state_reg <= `DQF_ST_IDLE;
                        end else if (dec_addr_in) begin
                            state_reg <= `DQF_ST_ADDR;
                        end else if (dec_read_in) begin
                            // Status reads land here with no address
                            state_reg <= `DQF_ST_DUMMY;
                            dcnt_reg <= 5'h00;
                        end else if (dec_write_in) begin
                            state_reg <= `DQF_ST_XFER;
                        end else begin
                            state_reg <= `DQF_ST_HOLD;
                        end
                    end
                    `DQF_ST_ADDR: begin
                        if (sck_rise) begin
                            got_rise_reg <= 1'b1;
                        end
                        if (cap_ev) begin
                            acc_reg <= acc_in;
                            bcnt_reg <= bcnt_reg + step;
                            if (bcnt_reg + step == alen) begin
                                addr_out <= a32_reg ? acc_in :
                                    {8'h00, acc_in[23:0]};
                                addr_valid_out <= 1'b1;
                                bcnt_reg <= 6'h00;
                                dcnt_reg <= ddr_reg ? 5'h01 : 5'h00;
                                if (mode_reg) begin
                                    state_reg <= `DQF_ST_MODE;
                                end else if (rd_reg) begin
                                    state_reg <= `DQF_ST_DUMMY;
                                end else if (wr_reg) begin
                                    state_reg <= `DQF_ST_XFER;
                                end else begin
                                    state_reg <= `DQF_ST_HOLD;
                                end
                            end
                        end
                    end
                    `DQF_ST_MODE: begin
                        if (cap_ev) begin
                            acc_reg <= acc_in;
                            bcnt_reg <= bcnt_reg + step;
                            if (bcnt_reg + step == `DQF_MODE_BITS) begin
                                mode_out <= acc_in[7:0];
                                // On a read, a matching upper nibble keeps the next
                                // command instruction-free
                                cont_mode_out <= rd_reg &&
                                    (acc_in[7:4] == CONT_MODE_NIB);
                                bcnt_reg <= 6'h00;
                                dcnt_reg <= ddr_reg ? 5'h01 : 5'h00;
                                state_reg <= rd_reg ? `DQF_ST_DUMMY :
                                    `DQF_ST_HOLD;
                            end
                        end
                    end
                    `DQF_ST_DUMMY: begin
                        // Latency is counted fall to fall
                        if (sck_fall) begin
                            if (dcnt_reg >= dummy_reg) begin
                                state_reg <= `DQF_ST_XFER;
                                driving_reg <= 1'b1;
                                oleft_reg <= 4'h0;
                            end else begin
                                dcnt_reg <= dcnt_reg + 5'h01;
                            end
                        end
                    end
                    `DQF_ST_XFER: begin
                        if (wr_reg) begin
                            if (sck_rise) begin
                                got_rise_reg <= 1'b1;
                            end
                            if (cap_ev) begin
                                if (quad_reg) begin
                                    wsh_reg <= {wsh_reg[11:8],
                                        lanes_s2_reg[7:4], wsh_reg[3:0],
                                        lanes_s2_reg[3:0]};
                                end else begin
                                    wsh_reg <= {wsh_reg[14:8],
                                        lanes_s2_reg[4], wsh_reg[6:0],
                                        lanes_s2_reg[0]};
                                end
                                bcnt_reg <= bcnt_reg + step;
                                if (bcnt_reg + step == `DQF_BYTE_BITS) begin
                                    bcnt_reg <= 6'h00;
                                    wr_valid_out <= 1'b1;
                                    if (quad_reg) begin
                                        wr_data_out <= {wsh_reg[11:8],
                                            lanes_s2_reg[7:4],
                                            wsh_reg[3:0],
                                            lanes_s2_reg[3:0]};
                                    end else begin
                                        wr_data_out <= {wsh_reg[14:8],
                                            lanes_s2_reg[4],
                                            wsh_reg[6:0],
                                            lanes_s2_reg[0]};
                                    end
                                end
                            end
                            if (wr_valid_out) begin
                                addr_out <= addr_out + 32'h1;
                            end
                        end
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end

            // Read output path: runs until select rises
            if (selected && !sel_fall && rd_reg && (first_out ||
                    (state_reg == `DQF_ST_XFER &&
                    (out_ev || (sck_fall && !driving_reg))))) begin
                driving_reg <= 1'b1;
                if (reload) begin
                    rd_take_out <= 1'b1;
                    addr_out <= addr_out + 32'h1;
                end
                if (quad_reg) begin
                    // Both halves return their byte together
                    lanes_out <= {src[15:12], src[7:4]};
                    lanes_oe_out <= 8'hFF;
                    osh_reg <= {src[11:8], 4'h0, src[3:0], 4'h0};
                    oleft_reg <= (reload ? `DQF_QUAD_XFERS :
                        oleft_reg) - 4'h1;
                end else begin
                    lanes_out <= {2'h0, src[15], 3'h0, src[7], 1'b0};
                    lanes_oe_out <= 8'h22;
                    osh_reg <= {src[14:8], 1'b0, src[6:0], 1'b0};
                    oleft_reg <= (reload ? `DQF_SINGLE_XFERS :
                        oleft_reg) - 4'h1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- include/dqf_defs.vh ----
// Constants for the dual-quad serial flash command framing block
`ifndef DQF_DEFS_VH
`define DQF_DEFS_VH

// ----------------------------------------------------------------
// Framing states
// ----------------------------------------------------------------
`define DQF_ST_IDLE 3'h0
`define DQF_ST_INST 3'h1
`define DQF_ST_DECODE 3'h2
`define DQF_ST_ADDR 3'h3
`define DQF_ST_MODE 3'h4
`define DQF_ST_DUMMY 3'h5
`define DQF_ST_XFER 3'h6
`define DQF_ST_HOLD 3'h7

// ----------------------------------------------------------------
// Field sizes and counts
// ----------------------------------------------------------------
`define DQF_INST_BITS 6'h08
`define DQF_ADDR_BITS_3B 6'h18
`define DQF_ADDR_BITS_4B 6'h20
`define DQF_MODE_BITS 6'h08
`define DQF_BYTE_BITS 6'h08
`define DQF_SINGLE_XFERS 4'h8
`define DQF_QUAD_XFERS 4'h2
`define DQF_CLK_MOD8_ZERO 3'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DQF_RST_ADDR 32'h00000000
`define DQF_RST_BYTE 8'h00
`define DQF_RST_PAIR 16'h0000
`define DQF_RST_LANES 8'h00

`endif

// ---- tb/dqf_frame_properties.sv ----
// Concurrent checks on the command framing block ports
`timescale 1ns/100ps
`default_nettype none
module dqf_frame_properties #(
    parameter [3:0] CONT_MODE_NIB = 4'hA
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Watched pins and outputs
    input wire logic sel_n_in,
    input wire logic [7:0] lanes_oe_out,
    input wire logic inst_valid_out,
    input wire logic [31:0] addr_out,
    input wire logic [7:0] mode_out,
    input wire logic cont_mode_out,
    input wire logic wr_valid_out,
    input wire logic rd_take_out,
    input wire logic cmd_exec_out,
    input wire logic cmd_reject_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (rst_in);
// Select passes a synchroniser, so it must be seen high for a while
sequence sel_idle_s;
    sel_n_in [*6];
endsequence
sequence byte_step_s;
    ##2 (addr_out == $past(addr_out, 2) + 32'h1);
endsequence
oe_release_a: assert property (sel_idle_s |-> lanes_oe_out == 8'h00)
    else $error("lanes driven while deselected");
oe_width_a: assert property (lanes_oe_out == 8'h00 ||
    lanes_oe_out == 8'h22 || lanes_oe_out == 8'hFF)
    else $error("lane enables form no legal width");
inst_pulse_a: assert property (inst_valid_out |->
    !sel_n_in ##1 !inst_valid_out) else $error("instruction pulse wrong");
end_excl_a: assert property ((cmd_exec_out || cmd_reject_out) |->
    sel_n_in && !(cmd_exec_out && cmd_reject_out))
    else $error("command end outcome wrong");
rd_step_a: assert property (rd_take_out |=>
    addr_out == $past(addr_out, 2) + 32'h1) else $error("read step wrong");
wr_step_a: assert property (wr_valid_out |-> byte_step_s)
    else $error("write address step wrong");
cont_enter_a: assert property ($rose(cont_mode_out) |->
    mode_out[7:4] == CONT_MODE_NIB) else $error("continuous entry wrong");
cont_leave_a: assert property ($fell(cont_mode_out) |->
    mode_out[7:4] != CONT_MODE_NIB) else $error("continuous exit wrong");
endmodule
bind dqf_cmd_frame dqf_frame_properties #(.CONT_MODE_NIB(CONT_MODE_NIB))
    dqf_frame_properties_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .sel_n_in(sel_n_in), .lanes_oe_out(lanes_oe_out),
    .inst_valid_out(inst_valid_out), .addr_out(addr_out),
    .mode_out(mode_out), .cont_mode_out(cont_mode_out),
    .wr_valid_out(wr_valid_out), .rd_take_out(rd_take_out),
    .cmd_exec_out(cmd_exec_out), .cmd_reject_out(cmd_reject_out));
`default_nettype wire

// ---- tb/dqf_host_model.sv ----
// Host controller model: select, serial clock and lanes
`timescale 1ns/100ps
`default_nettype none
module dqf_host_model (
    // Core clock used for pacing
    input wire logic clk_in,
    // Resolved lane levels
    input wire logic [7:0] lanes_rx_in,
    // Link pins driven by the host
    output logic sck_out,
    output logic sel_n_out,
    output logic [7:0] lanes_tx_out
);
initial begin
    sck_out = 1'b0;
    sel_n_out = 1'b1;
    lanes_tx_out = 8'h00;
end
task automatic open_cmd;
    sel_n_out = 1'b0;
    repeat (12) @(negedge clk_in);
endtask
// Clock idles low outside frames; select rises well after the last fall
task automatic close_cmd;
    repeat (12) @(negedge clk_in);
    sel_n_out = 1'b1;
    lanes_tx_out = ~lanes_tx_out;
    repeat (10) @(negedge clk_in);
endtask
// One beat per 25 core cycles; released lanes show the inverse of their
// last value so a stale level is never taken for data
task automatic shift(input int n, input logic [31:0] v, input bit quad,
                     input bit drive, output logic [31:0] got);
    got = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
        if (!drive)
            lanes_tx_out = ~lanes_tx_out;
        else if (quad)
            lanes_tx_out = {2{v[4 * i +: 4]}};
        else
            lanes_tx_out = {3'h0, v[i], 3'h0, v[i]};
        repeat (12) @(negedge clk_in);
        sck_out = 1'b1;
        got = {got[30:0], lanes_rx_in[1]};
        repeat (13) @(negedge clk_in);
        sck_out = 1'b0;
    end
endtask
// Quad beats on both edges; lanes move mid half-period, clear of each edge
task automatic ddr(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) begin
        repeat (6) @(negedge clk_in);
        lanes_tx_out = {2{v[4 * i +: 4]}};
        repeat (6 + i % 2) @(negedge clk_in);
        sck_out = ~sck_out;
    end
endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the command framing block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
logic core_clk_in = 1'b0;
logic rst_in = 1'b1;
logic busy_in = 1'b0;
wire sck_in, sel_n_in, inst_valid_out, addr_valid_out, cont_mode_out;
wire wr_valid_out, rd_take_out, cmd_exec_out, cmd_reject_out;
wire [7:0] host_lanes, lanes_in, lanes_out, lanes_oe_out, inst_out, mode_out;
wire [31:0] addr_out;
wire [15:0] wr_data_out, rd_data_in;
int bad_count = 0;
int compares = 0;
int execs = 0, rejects = 0, takes = 0, avals = 0;
// Opcodes are this bench's own arbitrary decode table
wire is_rd = inst_out == 8'h03 || inst_out == 8'h13;
wire is_qr = inst_out == 8'hEB;
wire is_wr = inst_out == 8'h02;
wire is_dw = inst_out == 8'h3E;
assign lanes_in = (lanes_oe_out & lanes_out) | (~lanes_oe_out & host_lanes);
assign rd_data_in = {~addr_out[7:0], addr_out[7:0]};
always #2.5 core_clk_in = ~core_clk_in;
always @(posedge core_clk_in) begin
    if (cmd_exec_out === 1'b1) execs++;
    if (cmd_reject_out === 1'b1) rejects++;
    if (rd_take_out === 1'b1) takes++;
    if (addr_valid_out === 1'b1) avals++;
end
dqf_host_model host (.clk_in(core_clk_in), .lanes_rx_in(lanes_in),
    .sck_out(sck_in), .sel_n_out(sel_n_in), .lanes_tx_out(host_lanes));
dqf_cmd_frame dqf_cmd_frame_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .sck_in(sck_in),
    .sel_n_in(sel_n_in), .lanes_in(lanes_in), .lanes_out(lanes_out),
    .lanes_oe_out(lanes_oe_out), .inst_out(inst_out),
    .inst_valid_out(inst_valid_out),
    .dec_addr_in(is_rd | is_qr | is_wr | is_dw),
    .dec_addr32_in(inst_out == 8'h13 || is_dw), .dec_quad_in(is_qr | is_dw),
    .dec_ddr_in(is_dw), .dec_mode_in(is_qr), .dec_dummy_in(5'h00),
    .dec_read_in(is_rd | is_qr | inst_out == 8'h05),
    .dec_write_in(is_wr | is_dw), .dec_array_in(is_rd | is_qr),
    .dec_busy_ok_in(inst_out == 8'h05), .busy_in(busy_in),
    .addr_out(addr_out), .addr_valid_out(addr_valid_out),
    .mode_out(mode_out), .cont_mode_out(cont_mode_out),
    .wr_data_out(wr_data_out), .wr_valid_out(wr_valid_out),
    .rd_data_in(rd_data_in), .rd_take_out(rd_take_out),
    .cmd_exec_out(cmd_exec_out), .cmd_reject_out(cmd_reject_out));
task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
        bad_count++;
        $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic t_frame(input int n, input bit ok);
    int e0, r0;
    logic [31:0] g;
    e0 = execs;
    r0 = rejects;
    host.open_cmd();
    host.shift(8, 32'h06, 1'b0, 1'b1, g);
    host.shift(n - 8, 32'h0, 1'b0, 1'b1, g);
    host.close_cmd();
    check("exec", execs - e0, ok);
    check("reject", rejects - r0, !ok);
endtask
task automatic t_read(input logic [7:0] op, input int w, input logic [31:0] a);
    logic [31:0] g;
    int a0;
    a0 = avals;
    host.open_cmd();
    host.shift(8, {24'h0, op}, 1'b0, 1'b1, g);
    host.shift(w, a, 1'b0, 1'b1, g);
    check("address done", avals - a0, 1);
    check("instruction", inst_out, op);
    host.shift(16, 32'h0, 1'b0, 1'b0, g);
    check("oe", lanes_oe_out, 8'h22);
    check("read data", g[15:0], {a[7:0], a[7:0] + 8'h01});
    host.close_cmd();
    check("oe idle", lanes_oe_out, 8'h00);
endtask
task automatic t_write;
    logic [31:0] g;
    int e0;
    e0 = execs;
    host.open_cmd();
    host.shift(32, 32'h020001FF, 1'b0, 1'b1, g);
    host.shift(16, 32'hC35A, 1'b0, 1'b1, g);
    host.close_cmd();
    check("write data", wr_data_out, 16'h5A5A);
    check("next address", addr_out, 32'h00000201);
    check("write exec", execs - e0, 1);
endtask
task automatic t_ddr;
    logic [31:0] g;
    int e0;
    e0 = execs;
    host.open_cmd();
    host.shift(8, 32'h3E, 1'b0, 1'b1, g);
    host.ddr(8, 32'h40302010);
    host.ddr(8, 32'h0F1E2D3C);
    host.close_cmd();
    check("ddr data", wr_data_out, 16'h3C3C);
    check("ddr address", addr_out, 32'h40302014);
    check("ddr exec", execs - e0, 1);
endtask
task automatic t_quad;
    logic [31:0] g;
    host.open_cmd();
    host.shift(8, 32'hEB, 1'b0, 1'b1, g);
    host.shift(8, 32'h3C2D10A5, 1'b1, 1'b1, g);
    host.close_cmd();
    check("quad data", lanes_out, 8'hE1);
    check("mode", mode_out, 8'hA5);
    check("cont mode", cont_mode_out, 1'b1);
    check("quad address", addr_out[31:8], 24'h003C2D);
    host.open_cmd();
    host.shift(8, 32'h1B2A4000, 1'b1, 1'b1, g);
    host.close_cmd();
    check("cont address", addr_out[31:8], 24'h001B2A);
    check("cont exit", cont_mode_out, 1'b0);
endtask
task automatic t_busy;
    logic [31:0] g;
    int t0;
    t0 = takes;
    busy_in = 1'b1;
    host.open_cmd();
    host.shift(32, 32'h03000040, 1'b0, 1'b1, g);
    host.shift(8, 32'h0, 1'b0, 1'b0, g);
    host.close_cmd();
    check("busy takes", takes - t0, 0);
    host.open_cmd();
    host.shift(8, 32'h05, 1'b0, 1'b1, g);
    host.shift(4, 32'h0, 1'b0, 1'b0, g);
    check("status oe", lanes_oe_out, 8'h22);
    host.close_cmd();
    busy_in = 1'b0;
endtask
initial begin
    repeat (6) @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    t_frame(8, 1'b1);
    t_frame(9, 1'b0);
    t_frame(16, 1'b1);
    t_read(8'h03, 24, 32'h001234FF);
    t_read(8'h13, 32, 32'hA1B2C3FE);
    t_write();
    t_ddr();
    t_quad();
    t_busy();
    finish_test();
end
initial begin
    #200000;
    bad_count++;
    finish_test();
end
endmodule
`default_nettype wire
